// *** design/pss_defines.svh ***
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH

// Value and time widths.
`define PSS_VAL_W        32
`define PSS_TIME_W       32

// Clock rate and press hold threshold.
`define PSS_CLK_HZ       10000000
`define PSS_HOLD_MS      500
`define PSS_HOLD_CYC     ((`PSS_CLK_HZ / 1000) * `PSS_HOLD_MS)

// Fixed-point fraction bits of the logarithmic step ratio.
`define PSS_RATIO_FRAC   16

// Reset values.
`define PSS_RST_VAL      32'h00000000

`endif

// *** design/pss_pkg.sv ***
package pss_pkg;

    typedef enum logic [2:0] {
        PSS_TGT_FREQ  = 3'h0,
        PSS_TGT_AMPL  = 3'h1,
        PSS_TGT_DCLEV = 3'h2,
        PSS_TGT_AUX1  = 3'h3,
        PSS_TGT_AUX2  = 3'h4
    } pss_target_e;

    typedef enum logic {
        PSS_LAW_LIN = 1'b0,
        PSS_LAW_LOG = 1'b1
    } pss_law_e;

    typedef enum logic [1:0] {
        PSS_END_REPEAT = 2'h0,
        PSS_END_UPDOWN = 2'h1,
        PSS_END_ONCE   = 2'h2
    } pss_end_e;

    // Gray codes along off -> ready -> run -> pause -> done; run to done changes two bits.
    typedef enum logic [2:0] {
        PSS_ST_OFF   = 3'b000,
        PSS_ST_READY = 3'b001,
        PSS_ST_RUN   = 3'b011,
        PSS_ST_PAUSE = 3'b010,
        PSS_ST_DONE  = 3'b110
    } pss_state_e;

    typedef enum logic [1:0] {
        PSS_PRESS_NONE  = 2'h0,
        PSS_PRESS_SHORT = 2'h1,
        PSS_PRESS_LONG  = 2'h2
    } pss_press_e;

endpackage

// *** design/pss_press_classify.sv ***
`timescale 1ns/10ps
`include "pss_defines.svh"

module pss_press_classify #(
    parameter int HOLD_CYC = `PSS_HOLD_CYC
) (
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic                button_pin,
    output pss_pkg::pss_press_e      press
);

    logic        sync1_r;
    logic        sync2_r;
    logic        level_r;
    logic        long_seen_r;
    logic        long_seen_nxt;
    logic [31:0] hold_cnt_r;
    logic [31:0] hold_cnt_nxt;
    pss_pkg::pss_press_e press_r;
    pss_pkg::pss_press_e press_nxt;

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    // Two flops before anything looks at the button.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            level_r <= 1'b0;
        end else begin
            sync1_r <= button_pin;
            sync2_r <= sync1_r;
            level_r <= sync2_r;
        end
    end

    // ------------------------------------------------------------
    // Hold timing
    // ------------------------------------------------------------
    // A long press fires once the threshold is reached, so the operator sees the
    // reset while still holding; a short press fires on release.
    always_comb begin
        hold_cnt_nxt  = hold_cnt_r;
        long_seen_nxt = long_seen_r;
        press_nxt     = pss_pkg::PSS_PRESS_NONE;
        if (sync2_r) begin
            if (!level_r) begin
                hold_cnt_nxt  = 32'h00000000;
                long_seen_nxt = 1'b0;
            end else if (!long_seen_r) begin
                if (hold_cnt_r >= 32'(HOLD_CYC - 1)) begin
                    long_seen_nxt = 1'b1;
                    press_nxt     = pss_pkg::PSS_PRESS_LONG;
                end else begin
                    hold_cnt_nxt = hold_cnt_r + 32'h00000001;
                end
            end
        end else if (level_r && !long_seen_r) begin
            press_nxt = pss_pkg::PSS_PRESS_SHORT;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hold_cnt_r  <= 32'h00000000;
            long_seen_r <= 1'b0;
            press_r     <= pss_pkg::PSS_PRESS_NONE;
        end else begin
            hold_cnt_r  <= hold_cnt_nxt;
            long_seen_r <= long_seen_nxt;
            press_r     <= press_nxt;
        end
    end

    assign press = press_r;

endmodule // pss_press_classify

// *** design/pss_scan_sequencer.sv ***
`timescale 1ns/10ps
`include "pss_defines.svh"

// Operation
// - One swept target chosen from five: frequency, amplitude, DC level, aux one, aux two.
// - Linear or logarithmic stepping law chosen by configuration.
// - Sweep the target from programmed start value toward programmed stop value.
// - Each step held one dwell; total time over dwell gives the step count.
// - Three end modes: repeat, up/down, once; repeat and up/down cycle forever.
// - Once mode halts at stop, requests recorder pause, raises done.
// - Scan on puts target at start, enters ready, lights ready, flags scan control.
// - Short press in ready starts sweep and lights run.
// - Short press while sweeping pauses; another short press resumes from there.
// - Long press returns to start, keeps ready lit, clears done.
// - Presses ignored while scanning is off or ready is not lit.
// - Scan off restores pre-scan value and clears the scan-control flag.
// - Settings are copied when scanning switches on or on a long press; edits in between do not matter.
// - Edited settings load only at scan re-enable or long press.

module pss_scan_sequencer #(
    parameter int VAL_W    = `PSS_VAL_W,
    parameter int TIME_W   = `PSS_TIME_W,
    parameter int HOLD_CYC = `PSS_HOLD_CYC
) (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic                   scan_toggle,
    input  wire logic                   run_pause_pin,
    input  wire logic [2:0]             cfg_target,
    input  wire logic                   cfg_law,
    input  wire logic [1:0]             cfg_end_mode,
    input  wire logic [VAL_W-1:0]       cfg_begin,
    input  wire logic [VAL_W-1:0]       cfg_end,
    input  wire logic [TIME_W-1:0]      cfg_scan_cycles,
    input  wire logic [TIME_W-1:0]      cfg_dwell_cycles,
    input  wire logic [VAL_W-1:0]       cfg_log_ratio,
    input  wire logic [VAL_W-1:0]       manual_value,
    output logic [VAL_W-1:0]            target_value,
    output logic [2:0]                  target_sel,
    output logic                        under_scan,
    output logic                        ready_led,
    output logic                        run_led,
    output logic                        pause_led,
    output logic                        done_led,
    output logic                        chart_pause_req
);

    localparam int PROD_W = 2 * VAL_W;

    pss_pkg::pss_press_e press;
    pss_pkg::pss_state_e state_r, state_nxt;

    logic                 tog_s1_r, tog_s2_r, tog_d_r;
    logic                 toggle_ev;
    logic [2:0]           sh_target_r, sh_target_nxt;
    logic                 sh_law_r, sh_law_nxt;
    logic [1:0]           sh_end_r, sh_end_nxt;
    logic [VAL_W-1:0]     sh_begin_r, sh_begin_nxt;
    logic [VAL_W-1:0]     sh_stop_r, sh_stop_nxt;
    logic [VAL_W-1:0]     sh_step_r, sh_step_nxt;
    logic [VAL_W-1:0]     sh_ratio_r, sh_ratio_nxt;
    logic [TIME_W-1:0]    sh_dwell_r, sh_dwell_nxt;
    logic [TIME_W-1:0]    sh_steps_r, sh_steps_nxt;
    logic [VAL_W-1:0]     saved_r, saved_nxt;
    logic [VAL_W-1:0]     value_r, value_nxt;
    logic [TIME_W-1:0]    dwell_cnt_r, dwell_cnt_nxt;
    logic [TIME_W-1:0]    step_idx_r, step_idx_nxt;
    logic                 falling_r, falling_nxt;
    logic                 chart_r, chart_nxt;
    logic [TIME_W-1:0]    step_count;
    logic [VAL_W-1:0]     span;
    logic [VAL_W-1:0]     lin_step;
    logic [PROD_W-1:0]    log_prod;
    logic [PROD_W-1:0]    log_quot;
    logic [VAL_W-1:0]     next_val;
    logic                 last_step;

    // ------------------------------------------------------------
    // Controls
    // ------------------------------------------------------------
    pss_press_classify #(
        .HOLD_CYC   (HOLD_CYC)
    ) u_press (
        .clk        (clk),
        .reset      (reset),
        .button_pin (run_pause_pin),
        .press      (press)
    );

    // The scan key is a pin level; toggle on each synchronised rising edge.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tog_s1_r <= 1'b0;
            tog_s2_r <= 1'b0;
            tog_d_r  <= 1'b0;
        end else begin
            tog_s1_r <= scan_toggle;
            tog_s2_r <= tog_s1_r;
            tog_d_r  <= tog_s2_r;
        end
    end
    assign toggle_ev = tog_s2_r & ~tog_d_r;

    // ------------------------------------------------------------
    // Step planning from live settings
    // ------------------------------------------------------------
    // The step count is computed at load time so the shadow holds ready-made
    // increments; the divider is large but only its result is ever stored.
    always_comb begin
        step_count = (cfg_dwell_cycles == '0) ? cfg_scan_cycles
                   : (cfg_scan_cycles / cfg_dwell_cycles);
        if (step_count == '0) begin
            step_count = TIME_W'(1);
        end
        span     = (cfg_end >= cfg_begin) ? (cfg_end - cfg_begin) : (cfg_begin - cfg_end);
        lin_step = span / VAL_W'(step_count);
    end

    // ------------------------------------------------------------
    // Next value along the sweep
    // ------------------------------------------------------------
    // Log mode multiplies by the per-step ratio (Q16) rising and divides falling.
    always_comb begin
        log_prod  = {{VAL_W{1'b0}}, value_r} * {{VAL_W{1'b0}}, sh_ratio_r};
        log_quot  = ({{VAL_W{1'b0}}, value_r} << `PSS_RATIO_FRAC)
                  / ((sh_ratio_r == '0) ? {{(PROD_W-1){1'b0}}, 1'b1} : {{VAL_W{1'b0}}, sh_ratio_r});
        last_step = (step_idx_r + TIME_W'(1)) >= sh_steps_r;
        if (sh_law_r == pss_pkg::PSS_LAW_LOG) begin
            next_val = falling_r ? log_quot[VAL_W-1:0]
                     : log_prod[VAL_W-1+`PSS_RATIO_FRAC:`PSS_RATIO_FRAC];
        end else begin
            next_val = ((sh_stop_r >= sh_begin_r) ^ falling_r) ? (value_r + sh_step_r)
                                                              : (value_r - sh_step_r);
        end
        if (last_step) begin
            next_val = falling_r ? sh_begin_r : sh_stop_r;
        end
    end

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    always_comb begin
        state_nxt     = state_r;
        sh_target_nxt = sh_target_r;
        sh_law_nxt    = sh_law_r;
        sh_end_nxt    = sh_end_r;
        sh_begin_nxt  = sh_begin_r;
        sh_stop_nxt   = sh_stop_r;
        sh_step_nxt   = sh_step_r;
        sh_ratio_nxt  = sh_ratio_r;
        sh_dwell_nxt  = sh_dwell_r;
        sh_steps_nxt  = sh_steps_r;
        saved_nxt     = saved_r;
        value_nxt     = value_r;
        dwell_cnt_nxt = dwell_cnt_r;
        step_idx_nxt  = step_idx_r;
        falling_nxt   = falling_r;
        chart_nxt     = chart_r;
        if (toggle_ev && state_r == pss_pkg::PSS_ST_OFF) begin
            saved_nxt = manual_value;
        end
        if (toggle_ev && state_r != pss_pkg::PSS_ST_OFF) begin
            state_nxt = pss_pkg::PSS_ST_OFF;
            value_nxt = saved_r;
            chart_nxt = 1'b0;
        end else if ((toggle_ev && state_r == pss_pkg::PSS_ST_OFF)
                  || (press == pss_pkg::PSS_PRESS_LONG && state_r != pss_pkg::PSS_ST_OFF)) begin
            // Load a fresh copy of the settings here and nowhere else.
            // An unused target code falls back to frequency so exactly one target is ever chosen.
            sh_target_nxt = (cfg_target > 3'h4) ? 3'h0 : cfg_target;
            sh_law_nxt    = cfg_law;
            sh_end_nxt    = cfg_end_mode;
            sh_begin_nxt  = cfg_begin;
            sh_stop_nxt   = cfg_end;
            sh_step_nxt   = lin_step;
            sh_ratio_nxt  = cfg_log_ratio;
            sh_dwell_nxt  = (cfg_dwell_cycles == '0) ? TIME_W'(1) : cfg_dwell_cycles;
            sh_steps_nxt  = step_count;
            value_nxt     = cfg_begin;
            dwell_cnt_nxt = '0;
            step_idx_nxt  = '0;
            falling_nxt   = 1'b0;
            chart_nxt     = 1'b0;
            state_nxt     = pss_pkg::PSS_ST_READY;
        end else begin
            unique case (state_r)
                pss_pkg::PSS_ST_OFF: begin
                    // Presses fall through unanswered while scanning is off.
                end
                pss_pkg::PSS_ST_READY: begin
                    if (press == pss_pkg::PSS_PRESS_SHORT) begin
                        state_nxt = pss_pkg::PSS_ST_RUN;
                    end
                end
                pss_pkg::PSS_ST_PAUSE: begin
                    if (press == pss_pkg::PSS_PRESS_SHORT) begin
                        state_nxt = pss_pkg::PSS_ST_RUN;
                    end
                end
                pss_pkg::PSS_ST_DONE: begin
                    // Held at the stop value until a long press or scan off.
                end
                pss_pkg::PSS_ST_RUN: begin
                    if (press == pss_pkg::PSS_PRESS_SHORT) begin
                        state_nxt = pss_pkg::PSS_ST_PAUSE;
                    end else if (dwell_cnt_r + TIME_W'(1) >= sh_dwell_r) begin
                        dwell_cnt_nxt = '0;
                        value_nxt     = next_val;
                        step_idx_nxt  = step_idx_r + TIME_W'(1);
                        if (last_step) begin
                            step_idx_nxt = '0;
                            unique case (sh_end_r)
                                pss_pkg::PSS_END_ONCE: begin
                                    state_nxt = pss_pkg::PSS_ST_DONE;
                                    chart_nxt = 1'b1;
                                end
                                pss_pkg::PSS_END_UPDOWN: begin
                                    falling_nxt = ~falling_r;
                                end
                                default: begin
                                    value_nxt = sh_begin_r;
                                end
                            endcase
                        end
                    end else begin
                        dwell_cnt_nxt = dwell_cnt_r + TIME_W'(1);
                    end
                end
                default: begin
                    state_nxt = pss_pkg::PSS_ST_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r     <= pss_pkg::PSS_ST_OFF;
            sh_target_r <= 3'h0;
            sh_law_r    <= 1'b0;
            sh_end_r    <= 2'h0;
            sh_begin_r  <= `PSS_RST_VAL;
            sh_stop_r   <= `PSS_RST_VAL;
            sh_step_r   <= `PSS_RST_VAL;
            sh_ratio_r  <= `PSS_RST_VAL;
            sh_dwell_r  <= '0;
            sh_steps_r  <= '0;
            saved_r     <= `PSS_RST_VAL;
            value_r     <= `PSS_RST_VAL;
            dwell_cnt_r <= '0;
            step_idx_r  <= '0;
            falling_r   <= 1'b0;
            chart_r     <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            sh_target_r <= sh_target_nxt;
            sh_law_r    <= sh_law_nxt;
            sh_end_r    <= sh_end_nxt;
            sh_begin_r  <= sh_begin_nxt;
            sh_stop_r   <= sh_stop_nxt;
            sh_step_r   <= sh_step_nxt;
            sh_ratio_r  <= sh_ratio_nxt;
            sh_dwell_r  <= sh_dwell_nxt;
            sh_steps_r  <= sh_steps_nxt;
            saved_r     <= saved_nxt;
            value_r     <= value_nxt;
            dwell_cnt_r <= dwell_cnt_nxt;
            step_idx_r  <= step_idx_nxt;
            falling_r   <= falling_nxt;
            chart_r     <= chart_nxt;
        end
    end

    // ------------------------------------------------------------
    // Indications
    // ------------------------------------------------------------
    // Ready stays lit in every scan-on state; long presses are honoured in all of them, short presses in all but done.
    assign target_value    = value_r;
    assign target_sel      = sh_target_r;
    assign under_scan      = (state_r != pss_pkg::PSS_ST_OFF);
    assign ready_led       = (state_r != pss_pkg::PSS_ST_OFF);
    assign run_led         = (state_r == pss_pkg::PSS_ST_RUN);
    assign pause_led       = (state_r == pss_pkg::PSS_ST_PAUSE);
    assign done_led        = (state_r == pss_pkg::PSS_ST_DONE);
    assign chart_pause_req = chart_r;

endmodule // pss_scan_sequencer

// *** verification/pss_scan_sva.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// Scan sequencer port checker
// ----------------------------------------
module pss_scan_sva #(
    parameter int VAL_W  = 32,
    parameter int TIME_W = 32
) (
    input wire logic              clk,
    input wire logic              reset,
    input wire logic              scan_toggle,
    input wire logic              run_pause_pin,
    input wire logic [2:0]        cfg_target,
    input wire logic              cfg_law,
    input wire logic [1:0]        cfg_end_mode,
    input wire logic [VAL_W-1:0]  cfg_begin,
    input wire logic [VAL_W-1:0]  cfg_end,
    input wire logic [TIME_W-1:0] cfg_scan_cycles,
    input wire logic [TIME_W-1:0] cfg_dwell_cycles,
    input wire logic [VAL_W-1:0]  cfg_log_ratio,
    input wire logic [VAL_W-1:0]  manual_value,
    input wire logic [VAL_W-1:0]  target_value,
    input wire logic [2:0]        target_sel,
    input wire logic              under_scan,
    input wire logic              ready_led,
    input wire logic              run_led,
    input wire logic              pause_led,
    input wire logic              done_led,
    input wire logic              chart_pause_req
);
    // All checks share the one clock; reset silences them.
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // State and indication relations, checked every cycle.
    ready_scan_a: assert property (under_scan == ready_led) else $error("ready and scan flag differ");
    led_excl_a: assert property ($onehot0({run_led, pause_led, done_led})) else $error("two leds lit");
    scan_begin_a: assert property ($rose(under_scan) |-> target_value == cfg_begin && !run_led)
        else $error("scan on not at begin value");
    pause_hold_a: assert property (pause_led && $past(pause_led) |-> $stable(target_value))
        else $error("value moved while paused");
    done_hold_a: assert property (done_led && $past(done_led) |-> $stable(target_value))
        else $error("value moved while done");
    off_hold_a: assert property (!under_scan && !$past(under_scan) |-> $stable(target_value))
        else $error("value moved while off");
    pause_entry_a: assert property ($rose(pause_led) |-> $past(run_led)) else $error("pause not from run");
    done_entry_a: assert property ($rose(done_led) |-> $past(run_led)) else $error("done not from run");
    chart_req_a: assert property ($rose(done_led) |-> ##[0:1] chart_pause_req) else $error("no chart pause");
    sel_hold_a: assert property (under_scan && $past(under_scan) && $changed(target_sel)
        |-> ready_led && !run_led && !pause_led && !done_led && target_value == cfg_begin)
        else $error("target changed outside a reload");
    scan_off_a: assert property ($fell(under_scan) |-> !run_led && !pause_led && !done_led && !chart_pause_req)
        else $error("indication left on at scan off");
    sel_range_a: assert property (under_scan |-> target_sel <= 3'h4) else $error("bad target code");
endmodule // pss_scan_sva

bind pss_scan_sequencer pss_scan_sva #(.VAL_W(VAL_W), .TIME_W(TIME_W)) u_sva (
    .clk(clk), .reset(reset), .scan_toggle(scan_toggle), .run_pause_pin(run_pause_pin),
    .cfg_target(cfg_target), .cfg_law(cfg_law), .cfg_end_mode(cfg_end_mode), .cfg_begin(cfg_begin),
    .cfg_end(cfg_end), .cfg_scan_cycles(cfg_scan_cycles), .cfg_dwell_cycles(cfg_dwell_cycles),
    .cfg_log_ratio(cfg_log_ratio), .manual_value(manual_value), .target_value(target_value),
    .target_sel(target_sel), .under_scan(under_scan), .ready_led(ready_led), .run_led(run_led),
    .pause_led(pause_led), .done_led(done_led), .chart_pause_req(chart_pause_req));

// *** verification/pss_panel.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// Operator panel model
// ----------------------------------------
module pss_panel (
    input  wire logic  clk,
    output logic       scan_toggle,
    output logic       run_pause_pin,
    output logic [31:0] manual_value
);
    // Keys rest released; every change lands on a falling edge.
    initial begin
        scan_toggle   = 1'b0;
        run_pause_pin = 1'b0;
        manual_value  = 32'h00000000;
    end
    // The gap after release lets the press settle before the next one.
    task automatic press(input int hold);
        @(negedge clk) run_pause_pin = 1'b1;
        repeat (hold) @(negedge clk);
        run_pause_pin = 1'b0;
        repeat (8) @(negedge clk);
    endtask
    // One tap toggles scanning; the key is never held long.
    task automatic tap_scan();
        @(negedge clk) scan_toggle = 1'b1;
        repeat (3) @(negedge clk);
        scan_toggle = 1'b0;
        repeat (8) @(negedge clk);
    endtask
    task automatic set_manual(input logic [31:0] v);
        @(negedge clk) manual_value = v;
    endtask
endmodule // pss_panel

// *** verification/pss_scan_sequencer_tb.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// Scan sequencer testbench
// ----------------------------------------
module pss_scan_sequencer_tb;
    localparam int DW = 20;
    logic        clk, reset, scan_toggle, run_pause_pin, cfg_law;
    logic [2:0]  cfg_target, target_sel;
    logic [1:0]  cfg_end_mode;
    logic [31:0] cfg_begin, cfg_end, cfg_scan_cycles, cfg_dwell_cycles, cfg_log_ratio;
    logic [31:0] manual_value, target_value, seed;
    logic        under_scan, ready_led, run_led, pause_led, done_led, chart_pause_req;
    int          mismatches, checks_done, cycles;

    pss_scan_sequencer #(.HOLD_CYC(8)) dut (.clk(clk), .reset(reset), .scan_toggle(scan_toggle),
        .run_pause_pin(run_pause_pin), .cfg_target(cfg_target), .cfg_law(cfg_law), .cfg_end_mode(cfg_end_mode),
        .cfg_begin(cfg_begin), .cfg_end(cfg_end), .cfg_scan_cycles(cfg_scan_cycles),
        .cfg_dwell_cycles(cfg_dwell_cycles), .cfg_log_ratio(cfg_log_ratio), .manual_value(manual_value),
        .target_value(target_value), .target_sel(target_sel), .under_scan(under_scan), .ready_led(ready_led),
        .run_led(run_led), .pause_led(pause_led), .done_led(done_led), .chart_pause_req(chart_pause_req));
    pss_panel panel (.clk(clk), .scan_toggle(scan_toggle), .run_pause_pin(run_pause_pin),
        .manual_value(manual_value));

    // A 100 ns clock; a hang is cut short after a fixed cycle budget.
    initial clk = 1'b0;
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            close_out();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Log cases use a ratio of two or four, so both laws stay exact.
    function automatic logic [31:0] exp_val(input logic law, input logic [31:0] b, d, input int k, rs);
        return law ? b << (k * rs) : b + 32'(k) * d;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bounded wait for the value to leave base; a stall returns base.
    task automatic wait_change(input logic [31:0] base, output logic [31:0] got);
        int n;
        n = 0;
        while (target_value === base && n < 4 * DW) begin
            @(negedge clk);
            n++;
        end
        got = target_value;
    endtask
    task close_out();
        if (mismatches == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // One full scan: start, pause, steps, end behaviour, long press, scan off.
    task automatic run_case(input int i);
        logic [31:0] b, d, nb, got, prev, man, dw;
        logic [1:0]  md;
        logic        law, rep;
        int          st, k, rs;
        law = ((i % 5) >= 3) || (i == 6);
        md = (i == 6) ? 2'h3 : (i % 5 == 1) ? pss_pkg::PSS_END_REPEAT
           : (i % 2 == 0) ? pss_pkg::PSS_END_UPDOWN : pss_pkg::PSS_END_ONCE;
        // Code 3 is decoded as repeat, so it is checked as repeat.
        rep = (md != pss_pkg::PSS_END_UPDOWN) && (md != pss_pkg::PSS_END_ONCE);
        st = 2 + int'(rnd() % 7);
        rs = 1 + int'(rnd() & 32'h1);
        // Dwell stays above the press latency so a pause lands inside one step.
        dw = 32'h10 + (rnd() & 32'hF);
        b = law ? 32'h1 + (rnd() & 32'hF) : rnd() & 32'hFFFF;
        d = 32'h1 + (rnd() & 32'hFF);
        man = rnd();
        panel.set_manual(man);
        cfg_target = 3'(i % 5);
        cfg_law = law;
        cfg_end_mode = md;
        cfg_begin = b;
        cfg_end = exp_val(law, b, d, st, rs);
        cfg_scan_cycles = 32'(st) * dw;
        cfg_dwell_cycles = dw;
        cfg_log_ratio = 32'h00010000 << rs;
        panel.tap_scan();
        chk(target_value, b);
        chk({29'h0, target_sel}, 32'(i % 5));
        chk({30'h0, ready_led, under_scan}, 32'h3);
        nb = rnd() & 32'hFFFF;
        cfg_begin = nb;
        cfg_end = nb;
        cfg_dwell_cycles = 32'h1 + (rnd() & 32'h7);
        cfg_scan_cycles = rnd() & 32'hFFF;
        cfg_log_ratio = rnd();
        cfg_law = ~law;
        cfg_end_mode = 2'(rnd());
        cfg_target = 3'((i + 1) % 5);
        panel.set_manual(rnd());
        prev = b;
        panel.press(2);
        chk({31'h0, run_led}, 32'h1);
        for (k = 1; k <= st; k++) begin
            wait_change(prev, got);
            chk(got, (rep && k == st) ? b : exp_val(law, b, d, k, rs));
            prev = got;
            if (k == 1) begin
                panel.press(2);
                chk({31'h0, pause_led}, 32'h1);
                repeat (3 * dw) @(negedge clk);
                chk(target_value, prev);
                panel.press(2);
            end
        end
        if (md == pss_pkg::PSS_END_ONCE) begin
            panel.press(2);
            repeat (DW) @(negedge clk);
            chk(target_value, prev);
            chk({29'h0, done_led, chart_pause_req, run_led}, 32'h6);
        end else begin
            wait_change(prev, got);
            chk(got, exp_val(law, b, d, md == pss_pkg::PSS_END_UPDOWN ? st - 1 : 1, rs));
        end
        panel.press(14);
        chk(target_value, nb);
        chk({27'h0, ready_led, run_led, pause_led, done_led, chart_pause_req}, 32'h10);
        chk({29'h0, target_sel}, 32'((i + 1) % 5));
        panel.tap_scan();
        chk(target_value, man);
        chk({27'h0, under_scan, ready_led, run_led, pause_led, done_led}, 32'h0);
        panel.press(2);
        chk({31'h0, run_led}, 32'h0);
        chk(target_value, man);
    endtask

    // Reset for eight cycles, then ten scans across all modes and targets.
    initial begin
        seed = 32'h0000000D;
        mismatches = 0;
        checks_done = 0;
        cycles = 0;
        reset = 1'b1;
        cfg_target = 3'h0;
        cfg_law = 1'b0;
        cfg_end_mode = 2'h0;
        cfg_begin = 32'h0;
        cfg_end = 32'h0;
        cfg_scan_cycles = 32'h0;
        cfg_dwell_cycles = 32'h0;
        cfg_log_ratio = 32'h0;
        repeat (8) @(posedge clk);
        @(negedge clk) reset = 1'b0;
        repeat (2) @(negedge clk);
        for (int i = 0; i < 10; i++) run_case(i);
        close_out();
    end
endmodule // pss_scan_sequencer_tb
